// ==== rtl/hws_pkg.sv ====
// Purpose: Shared constants and types for the halt/wake/reset sequencer
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   Offsets are byte addresses
package hws_pkg;
    localparam int          SST_CYCLES       = 1024;
    localparam int          PORT_LINES       = 8;
    localparam int          INT_SOURCES      = 2;
    localparam logic [7:0]  PORT_WAKE_OPTION = 8'hFF;

    localparam logic [7:0]  OFS_STATUS = 8'h00;
    localparam logic [7:0]  OFS_EVENT  = 8'h04;
    localparam logic [7:0]  OFS_MASK   = 8'h08;
    localparam logic [7:0]  OFS_PWAKE  = 8'h0C;

    localparam int          STAT_TO   = 0;
    localparam int          STAT_PDF  = 1;
    localparam int          STAT_HALT = 2;
    localparam int          STAT_RUN  = 3;

    localparam int          EVT_W     = 4;
    localparam int          EVT_WAKE  = 0;
    localparam int          EVT_WARM  = 1;
    localparam int          EVT_CHIP  = 2;
    localparam int          EVT_PIN   = 3;

    localparam logic [EVT_W-1:0] MASK_RST  = 4'h0;
    localparam logic [7:0]       PWAKE_RST = 8'hFF;
    localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;

    typedef enum logic [5:0] {
        ST_PWRUP  = 6'h01,
        ST_PINRST = 6'h02,
        ST_RUN    = 6'h04,
        ST_HALT   = 6'h08,
        ST_WAKE   = 6'h10,
        ST_ACK    = 6'h20
    } hws_state_e;

    typedef enum logic [1:0] {
        WK_PORT = 2'h0,
        WK_INT  = 2'h1,
        WK_WDT  = 2'h2
    } hws_wake_e;
endpackage

// ==== rtl/hws_wake_edge.sv ====
// Purpose: Synchronise port wake lines and flag enabled falling edges
// Assumes: Lines idle high; ref_clk keeps running while the core halts
// Notes:   Output is a registered one-cycle pulse
`timescale 1ns/100ps
module hws_wake_edge #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] lines,
    input  wire logic [WIDTH-1:0] enables,
    output logic                  hit
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '1;
            sync2 <= '1;
            prev  <= '1;
        end else begin
            sync1 <= lines;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Edge looks only at the second and third stages, never the metastable first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= |(prev & ~sync2 & enables);
        end
    end

    chk_edge_pulse: assert property (@(posedge clk) disable iff (rst)
        (|(prev & ~sync2 & enables)) |=> hit)
        else $error("enabled falling edge not flagged");
endmodule

// ==== rtl/hws_sequencer.sv ====
// Purpose: Halt exit, start-up delay and reset cause sequencing
// Assumes: Core pulses haltExec, wdtClearExec, wdtOverflow for one cycle
// Notes:   ref_clk is the always-on clock; sysOscRun gates the core clock
// Function
// - Halt is left on reset pin, interrupt request, port falling edge or watchdog overflow.
// - Watchdog overflow in halt gives a warm reset of program counter and stack pointer only.
// - Power-down flag clears at power-up or watchdog clear and sets on halt.
// - Timeout flag sets on a watchdog time-out in run or halt.
// - Each port line can be enabled as a wake source by a build option.
// - A port wake resumes at the instruction after the halt.
// - An interrupt wake is serviced only if enabled and the stack is not full, else execution continues.
// - Every wake waits the start-up delay; execution then resumes at once, one cycle later for an acknowledged interrupt wake.
// - An interrupt acknowledge after wake starts one cycle after the delay ends.
// - An interrupt already pending at halt entry cannot wake the device.
// - Reset causes leave timeout and power-down flags in their documented combinations.
// - Watchdog time-out while running gives a full chip reset.
// - Start-up delay applies at power-up and every wake but not after the reset pin.
// - Chip reset restarts the core, and restarts the watchdog except at power-up.
// - Halt stops the system oscillator while the watchdog oscillator may run.
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module hws_sequencer import hws_pkg::*; #(
    parameter int         STARTUP_CYCLES = SST_CYCLES,
    parameter int         PWIDTH         = PORT_LINES,
    parameter logic [7:0] WAKE_OPTION    = PORT_WAKE_OPTION
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic                   haltExec,
    input  wire logic                   wdtClearExec,
    input  wire logic                   wdtOverflow,
    input  wire logic                   wdtOscSelect,
    input  wire logic                   externalResetPinN,
    input  wire logic [PWIDTH-1:0]      wakePortLines,
    input  wire logic [INT_SOURCES-1:0] intRequest,
    input  wire logic [INT_SOURCES-1:0] intEnable,
    input  wire logic                   masterIntEnable,
    input  wire logic                   stackFull,
    output logic                        sysOscRun,
    output logic                        wdtOscRun,
    output logic                        wdtRestart,
    output logic                        fetchEnable,
    output logic                        chipReset,
    output logic                        warmReset,
    output logic                        resumeNext,
    output logic                        intAckStart,
    output logic                        halted,
    output logic                        timeoutFlag,
    output logic                        powerdownFlag,
    output logic                        irq
);
    localparam int CW = $clog2(STARTUP_CYCLES);
    localparam logic [CW-1:0] CNT_LAST = CW'(STARTUP_CYCLES - 1);

    if (STARTUP_CYCLES < 2) $error("STARTUP_CYCLES must be at least 2");
    if (PWIDTH < 1 || PWIDTH > 8) $error("PWIDTH must be 1 to 8");

    hws_state_e             state;
    hws_state_e             next_state;
    hws_wake_e              wakeCause;
    logic [CW-1:0]          cnt;
    logic                   cntDone;
    logic                   pinSync1;
    logic                   pinSync2;
    logic                   pinLow;
    logic                   portHit;
    logic                   intWake;
    logic                   takeInt;
    logic [INT_SOURCES-1:0] intArmed;
    logic [EVT_W-1:0]       events;
    logic [EVT_W-1:0]       evtSet;
    logic [EVT_W-1:0]       evtMask;
    logic [7:0]             portWakeEn;
    logic                   dpWrite;
    logic [7:0]             dpAddr;
    logic                   addrPhase;

    // Reset pin: plain two-stage synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinSync1 <= 1'b1;
            pinSync2 <= 1'b1;
        end else begin
            pinSync1 <= externalResetPinN;
            pinSync2 <= pinSync1;
        end
    end
    assign pinLow = ~pinSync2;

    hws_wake_edge #(
        .WIDTH (PWIDTH)
    ) u_wake_edge (
        .clk     (ref_clk),
        .rst     (rst),
        .lines   (wakePortLines),
        .enables (WAKE_OPTION[PWIDTH-1:0] & portWakeEn[PWIDTH-1:0]),
        .hit     (portHit)
    );

    assign intWake = |(intArmed & intRequest);
    assign cntDone = (cnt == CNT_LAST);
    assign takeInt = (wakeCause == WK_INT) && masterIntEnable &&
                     (|(intEnable & intRequest)) && !stackFull;

    always_comb begin
        next_state = state;
        case (state)
            ST_PWRUP: begin
                if (pinLow) next_state = ST_PINRST;
                else if (cntDone) next_state = ST_RUN;
            end
            ST_PINRST: begin
                if (!pinLow) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (pinLow) next_state = ST_PINRST;
                else if (wdtOverflow) next_state = ST_RUN;
                else if (haltExec) next_state = ST_HALT;
            end
            ST_HALT: begin
                if (pinLow) next_state = ST_PINRST;
                else if (wdtOverflow || portHit || intWake) next_state = ST_WAKE;
            end
            ST_WAKE: begin
                if (pinLow) next_state = ST_PINRST;
                else if (cntDone && takeInt) next_state = ST_ACK;
                else if (cntDone) next_state = ST_RUN;
            end
            ST_ACK: begin
                if (pinLow) next_state = ST_PINRST;
                else next_state = ST_RUN;
            end
            default: next_state = ST_PWRUP;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_PWRUP;
        end else begin
            state <= next_state;
        end
    end

    // Start-up delay counter, cleared on every entry into a delay state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if ((state == ST_PWRUP || state == ST_WAKE) && !cntDone) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Wake cause and armed interrupts; watchdog outranks port, port outranks interrupt
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wakeCause <= WK_PORT;
            intArmed  <= '0;
        end else begin
            if (state == ST_RUN && next_state == ST_HALT) begin
                intArmed <= ~intRequest;
            end
            if (state == ST_HALT && next_state == ST_WAKE) begin
                if (wdtOverflow) wakeCause <= WK_WDT;
                else if (portHit) wakeCause <= WK_PORT;
                else wakeCause <= WK_INT;
            end
        end
    end

    // Flags: set wins over clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timeoutFlag   <= 1'b0;
            powerdownFlag <= 1'b0;
        end else begin
            if ((state == ST_RUN && wdtClearExec) || (state == ST_RUN && next_state == ST_HALT) ||
                (state == ST_HALT && pinLow)) begin
                timeoutFlag <= 1'b0;
            end
            if (wdtOverflow && !pinLow && (state == ST_RUN || state == ST_HALT)) begin
                timeoutFlag <= 1'b1;
            end
            if (state == ST_RUN && wdtClearExec) begin
                powerdownFlag <= 1'b0;
            end
            if (state == ST_RUN && next_state == ST_HALT) begin
                powerdownFlag <= 1'b1;
            end
        end
    end

    // Core-facing controls, all registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sysOscRun   <= 1'b1;
            wdtOscRun   <= 1'b0;
            wdtRestart  <= 1'b0;
            fetchEnable <= 1'b0;
            chipReset   <= 1'b1;
            warmReset   <= 1'b0;
            resumeNext  <= 1'b0;
            intAckStart <= 1'b0;
            halted      <= 1'b0;
        end else begin
            sysOscRun   <= (next_state != ST_HALT);
            wdtOscRun   <= wdtOscSelect;
            fetchEnable <= (next_state == ST_RUN);
            halted      <= (next_state == ST_HALT);
            chipReset   <= (next_state == ST_PWRUP) || (next_state == ST_PINRST) ||
                           (state == ST_RUN && wdtOverflow && !pinLow);
            wdtRestart  <= (next_state == ST_PINRST) || (state == ST_RUN && next_state == ST_HALT) ||
                           (state == ST_RUN && wdtOverflow && !pinLow);
            warmReset   <= (state == ST_HALT && wdtOverflow && !pinLow);
            resumeNext  <= (state == ST_WAKE && next_state == ST_RUN);
            intAckStart <= (state == ST_ACK && next_state == ST_RUN);
        end
    end

    always_comb begin
        evtSet = '0;
        evtSet[EVT_WAKE] = (state == ST_HALT && next_state == ST_WAKE);
        evtSet[EVT_WARM] = (state == ST_HALT && wdtOverflow && !pinLow);
        evtSet[EVT_CHIP] = (state == ST_RUN && wdtOverflow && !pinLow);
        evtSet[EVT_PIN]  = (state != ST_PINRST && next_state == ST_PINRST);
    end

    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] d;
        d = '0;
        if (a == OFS_STATUS) begin
            d[STAT_TO]   = timeoutFlag;
            d[STAT_PDF]  = powerdownFlag;
            d[STAT_HALT] = (state == ST_HALT);
            d[STAT_RUN]  = (state == ST_RUN);
        end else if (a == OFS_EVENT) begin
            d[EVT_W-1:0] = events;
        end else if (a == OFS_MASK) begin
            d[EVT_W-1:0] = evtMask;
        end else if (a == OFS_PWAKE) begin
            d[7:0] = portWakeEn;
        end
        return d;
    endfunction

    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

    // Zero-wait slave; reads sampled in the address phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dpWrite   <= 1'b0;
            dpAddr    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dpWrite   <= addrPhase && hwrite;
            dpAddr    <= haddr[7:0];
            hrdata    <= (addrPhase && !hwrite) ? regRead(haddr[7:0]) : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            events     <= '0;
            evtMask    <= MASK_RST;
            portWakeEn <= PWAKE_RST;
        end else begin
            events <= (events & ~((dpWrite && dpAddr == OFS_EVENT) ? hwdata[EVT_W-1:0] : '0)) | evtSet;
            if (dpWrite && dpAddr == OFS_MASK) evtMask <= hwdata[EVT_W-1:0];
            if (dpWrite && dpAddr == OFS_PWAKE) portWakeEn <= hwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(events & evtMask);
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    int wakeLen;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) wakeLen <= 0;
        else if (state == ST_WAKE) wakeLen <= wakeLen + 1;
        else wakeLen <= 0;
    end

    chk_halt_exit: assert property (
        state == ST_HALT && !pinLow && (wdtOverflow || portHit || intWake) |=> state == ST_WAKE)
        else $error("halt not left on wake event");
    chk_warm_only: assert property (
        state == ST_HALT && wdtOverflow && !pinLow |=> warmReset && !chipReset ##1 !warmReset)
        else $error("watchdog in halt not a warm reset");
    chk_pdf_set: assert property (
        state == ST_RUN && haltExec && !pinLow && !wdtOverflow |=> powerdownFlag && halted)
        else $error("power-down flag not set on halt");
    chk_to_set: assert property (
        wdtOverflow && !pinLow && (state == ST_RUN || state == ST_HALT) |=> timeoutFlag)
        else $error("timeout flag not set");
    chk_wake_len: assert property (
        state == ST_WAKE && next_state != ST_WAKE && !pinLow |-> wakeLen == STARTUP_CYCLES - 1)
        else $error("start-up delay length wrong");
    chk_ack_late: assert property (
        intAckStart |-> $past(state, 2) == ST_WAKE && !resumeNext && fetchEnable)
        else $error("interrupt acknowledge not one cycle late");
    chk_int_block: assert property (
        state == ST_HALT && $past(state) == ST_RUN |-> (intArmed & $past(intRequest)) == '0)
        else $error("pending interrupt left armed");
    chk_pin_flags: assert property (
        state == ST_HALT && pinLow |=> !timeoutFlag && powerdownFlag && chipReset)
        else $error("pin reset in halt flags wrong");
    chk_wdt_chip: assert property (
        state == ST_RUN && wdtOverflow && !pinLow |=> chipReset && timeoutFlag && !warmReset)
        else $error("watchdog in run not a chip reset");
    chk_pin_nodly: assert property (
        state == ST_PINRST && !pinLow |=> fetchEnable && !chipReset)
        else $error("reset pin release delayed");
    chk_osc_stop: assert property (
        state == ST_HALT |-> !sysOscRun)
        else $error("oscillator running in halt");
    chk_fetch_hold: assert property (
        (state == ST_WAKE || state == ST_PWRUP) |-> !fetchEnable)
        else $error("fetch enabled during start-up delay");

    cov_port_wake: cover property (state == ST_WAKE && wakeCause == WK_PORT && cntDone ##1 resumeNext);
    cov_warm: cover property (warmReset);
    cov_int_ack: cover property (intAckStart);
    cov_pin_halt: cover property (state == ST_HALT && pinLow);
endmodule

// ==== dv/hws_core_model.sv ====
// Purpose: Core and pin side of the halt/wake sequencer
// Assumes: Instructions leave the core as one-cycle pulses
// Notes:   Port lines rest high through their pull-ups
`timescale 1ns/100ps
module hws_core_model (
    input  wire logic clk,
    input  wire logic fetchEnable,
    output logic       haltExec,
    output logic       wdtClearExec,
    output logic       wdtOverflow,
    output logic       externalResetPinN,
    output logic [7:0] wakePortLines,
    output logic [1:0] intRequest
);
    initial begin
        haltExec          = 1'b0;
        wdtClearExec      = 1'b0;
        wdtOverflow       = 1'b0;
        externalResetPinN = 1'b1;
        wakePortLines     = 8'hFF;
        intRequest        = 2'h0;
    end

    // An instruction waits up to 64 edges for the core to fetch
    task automatic instr(input int kind);
        int k;
        k = 0;
        while (fetchEnable !== 1'b1 && k < 64) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        haltExec     <= (kind == 0);
        wdtClearExec <= (kind != 0);
        @(posedge clk);
        haltExec     <= 1'b0;
        wdtClearExec <= 1'b0;
    endtask

    task automatic overflow();
        @(posedge clk);
        wdtOverflow <= 1'b1;
        @(posedge clk);
        wdtOverflow <= 1'b0;
    endtask

    task automatic line(input int i, input logic v);
        @(posedge clk);
        wakePortLines[i] <= v;
    endtask

    task automatic pin(input logic v);
        @(posedge clk);
        externalResetPinN <= v;
    endtask

    task automatic req(input logic [1:0] v);
        @(posedge clk);
        intRequest <= v;
    endtask
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the halt/wake sequencer
// Assumes: Zero-wait bus slave, short start-up delay
// Notes:   Outputs are sampled 1 ns after the edge
`timescale 1ns/100ps
module tb_top import hws_pkg::*;;
    localparam int SC = 8;
    logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, intRequest, intEnable;
    logic [2:0]  hsize;
    logic [7:0]  wakePortLines;
    logic        haltExec, wdtClearExec, wdtOverflow, wdtOscSelect, externalResetPinN;
    logic        masterIntEnable, stackFull, sysOscRun, wdtOscRun, wdtRestart, fetchEnable;
    logic        chipReset, warmReset, resumeNext, intAckStart, halted, timeoutFlag, powerdownFlag, irq;
    int          errorCnt, checkCount, n;

    assign hready = hreadyout;
    always #2.5 ref_clk = ~ref_clk;

    hws_core_model u_core (.clk(ref_clk), .fetchEnable(fetchEnable), .haltExec(haltExec),
        .wdtClearExec(wdtClearExec), .wdtOverflow(wdtOverflow), .externalResetPinN(externalResetPinN),
        .wakePortLines(wakePortLines), .intRequest(intRequest));

    hws_sequencer #(.STARTUP_CYCLES(SC)) u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .haltExec(haltExec),
        .wdtClearExec(wdtClearExec), .wdtOverflow(wdtOverflow), .wdtOscSelect(wdtOscSelect),
        .externalResetPinN(externalResetPinN), .wakePortLines(wakePortLines), .intRequest(intRequest),
        .intEnable(intEnable), .masterIntEnable(masterIntEnable), .stackFull(stackFull),
        .sysOscRun(sysOscRun), .wdtOscRun(wdtOscRun), .wdtRestart(wdtRestart), .fetchEnable(fetchEnable),
        .chipReset(chipReset), .warmReset(warmReset), .resumeNext(resumeNext), .intAckStart(intAckStart),
        .halted(halted), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .irq(irq));

    task automatic finish_test();
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return fetchEnable === 1'b1;
            1: return resumeNext === 1'b1;
            default: return (resumeNext | intAckStart) === 1'b1;
        endcase
    endfunction

    // Counts edges up to and including the one that shows the event
    task automatic wait_for(input int w, input int lim, output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            #1;
            c++;
        end while (!pick(w) && c < lim);
        if (!pick(w)) begin
            check("event wait", 32'h0, 32'h1);
            finish_test();
        end
    endtask

    task automatic hwait();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hready !== 1'b1 && k < 16);
        if (k >= 16) begin
            check("bus ready", 32'h0, 32'h1);
            finish_test();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hwait();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        hwait();
        r = hrdata;
        hwdata <= 32'h0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(nm, r, exp);
    endtask

    initial begin
        ref_clk = 0; rst = 1; hsel = 0; hwrite = 0; htrans = 2'h0; hsize = 3'h2;
        haddr = 32'h0; hwdata = 32'h0; wdtOscSelect = 1; intEnable = 2'h3;
        masterIntEnable = 1; stackFull = 0; errorCnt = 0; checkCount = 0;
        tick(4);
        check("reset chip", 32'(chipReset), 32'h1);
        @(posedge ref_clk);
        rst <= 1'b0;
        wait_for(0, SC + 10, n);
        check("powerup delay", 32'(n >= SC && n <= SC + 2), 32'h1);
        check("powerup flags", {timeoutFlag, powerdownFlag}, 32'h0);
        rdchk("status", OFS_STATUS, 32'h8);
        rdchk("mask", OFS_MASK, 32'h0);
        rdchk("portwake", OFS_PWAKE, 32'hFF);
        rdchk("unmapped", 8'h10, 32'h0);
        check("resp okay", {hreadyout, hresp}, 32'h2);
        ahb(1'b1, OFS_STATUS, 32'hFFFF, rd);
        rdchk("status ro", OFS_STATUS, 32'h8);
        ahb(1'b1, OFS_MASK, 32'h1, rd);
        rdchk("mask rw", OFS_MASK, 32'h1);
        // Port wake, then the sticky event drives irq
        u_core.instr(0);
        #1;
        check("halted", 32'(halted), 32'h1);
        check("osc stop", {sysOscRun, wdtOscRun, wdtRestart}, 32'h3);
        check("halt flags", {timeoutFlag, powerdownFlag}, 32'h1);
        u_core.line(3, 1'b0);
        wait_for(1, SC + 20, n);
        check("port resume", 32'(n >= SC && n <= SC + 6), 32'h1);
        check("port fetch", {fetchEnable, intAckStart}, 32'h2);
        u_core.line(3, 1'b1);
        rdchk("event wake", OFS_EVENT, 32'h1);
        check("irq set", 32'(irq), 32'h1);
        ahb(1'b1, OFS_EVENT, 32'h1, rd);
        ahb(1'b1, OFS_MASK, 32'h0, rd);
        tick(2);
        check("irq clear", 32'(irq), 32'h0);
        // Watchdog in halt: warm reset and exact delay
        u_core.instr(0);
        u_core.overflow();
        #1;
        check("warm", {warmReset, chipReset}, 32'h2);
        check("warm flags", {timeoutFlag, powerdownFlag}, 32'h3);
        wait_for(1, SC + 20, n);
        check("warm delay", n, SC);
        check("warm fetch", {fetchEnable, sysOscRun}, 32'h3);
        rdchk("event warm", OFS_EVENT, 32'h3);
        check("irq masked", 32'(irq), 32'h0);
        ahb(1'b1, OFS_EVENT, 32'hF, rd);
        // Watchdog while running: chip reset without delay
        u_core.overflow();
        #1;
        check("run chip", {chipReset, warmReset, fetchEnable, wdtRestart}, 32'hB);
        check("run flags", {timeoutFlag, powerdownFlag}, 32'h3);
        u_core.instr(1);
        #1;
        check("clear pdf", 32'(powerdownFlag), 32'h0);
        u_core.overflow();
        #1;
        check("run flags2", {timeoutFlag, powerdownFlag}, 32'h2);
        u_core.pin(1'b0);
        tick(6);
        check("pin run", {chipReset, timeoutFlag, powerdownFlag}, 32'h6);
        u_core.pin(1'b1);
        wait_for(0, 12, n);
        // Interrupt wake: acknowledged, then refused by full stack, disabled source, master off
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            stackFull       <= (m == 1);
            intEnable       <= (m == 2) ? 2'h2 : 2'h3;
            masterIntEnable <= (m != 3);
            u_core.instr(0);
            u_core.req(2'h1);
            wait_for(2, SC + 20, n);
            check("int ack", 32'(intAckStart), 32'(m == 0));
            check("int next", 32'(resumeNext), 32'(m != 0));
            u_core.req(2'h0);
            tick(2);
        end
        // Pending request and disabled line cannot wake; pin can
        ahb(1'b1, OFS_PWAKE, 32'hFE, rd);
        wdtOscSelect <= 1'b0;
        u_core.req(2'h2);
        u_core.instr(0);
        u_core.line(0, 1'b0);
        tick(3 * SC + 8);
        check("no wake", {halted, wdtOscRun}, 32'h2);
        u_core.pin(1'b0);
        tick(6);
        check("pin halt", {timeoutFlag, powerdownFlag}, 32'h1);
        u_core.pin(1'b1);
        wait_for(0, 12, n);
        check("pin no delay", 32'(n <= 6), 32'h1);
        u_core.line(0, 1'b1);
        u_core.req(2'h0);
        tick(2);
        // Second power-up in mid-run: flags back to zero, full delay again
        @(posedge ref_clk);
        rst <= 1'b1;
        tick(2);
        check("rerun reset", {chipReset, fetchEnable, powerdownFlag}, 32'h4);
        @(posedge ref_clk);
        rst <= 1'b0;
        wait_for(0, SC + 10, n);
        check("rerun delay", 32'(n >= SC && n <= SC + 2), 32'h1);
        finish_test();
    end

    initial begin
        #400000;
        errorCnt++;
        finish_test();
    end
endmodule
